// *** src/mbsc_pkg.sv ***
// shared constants and types for the coil and register-read slave
`default_nettype none
package mbsc_pkg;
  // ****************************************************************
  // coil map
  // ****************************************************************
  localparam logic [15:0] COIL_LOW_LIMIT_ALARM_FLAG = 16'h0070;
  localparam logic [15:0] COIL_HIGH_LIMIT_ALARM_FLAG = 16'h0071;
  localparam logic [15:0] COIL_LOOP_OVER = 16'h0072;
  localparam logic [15:0] COIL_LOOP_UNDER = 16'h0073;
  localparam logic [15:0] COIL_TEMP_RANGE = 16'h0074;
  localparam logic [15:0] COIL_MEAS_RANGE = 16'h0075;
  localparam logic [15:0] COIL_RELAY_ONE = 16'h0076;
  localparam logic [15:0] COIL_RELAY_TWO = 16'h0077;
  localparam logic [15:0] COIL_CLEAN = 16'h0078;
  localparam logic [15:0] COIL_MEAS_STATE = 16'h0079;
  localparam logic [15:0] COIL_END = 16'h007A;
  localparam int COIL_COUNT = 10;
  localparam int RELAY_COUNT = 3;
  localparam logic FLAG_RST = 1'b0;
  localparam logic MEAS_RST = 1'b1;
  // ****************************************************************
  // function and exception codes
  // ****************************************************************
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] MAX_REGS = 16'h007D;
  // ****************************************************************
  // check fields and buffers
  // ****************************************************************
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int RX_DEPTH = 32;
  localparam int TX_DEPTH = 256;
  localparam logic [5:0] RX_MIN_BODY = 6'h06;
  typedef enum logic [3:0] {
    ST_COLLECT = 4'b0001,
    ST_DECODE = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_SEND = 4'b1000
  } mbsc_state_type;
endpackage : mbsc_pkg
`default_nettype wire

// *** src/mbsc_chk.sv ***
// running crc and lrc over a byte stream
`timescale 1ns/1ps
`default_nettype none
module mbsc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] crc_o,
  output logic [7:0] lrc_o
);
  import mbsc_pkg::*;
  logic [15:0] crc_q;
  logic [7:0] sum_q;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // ****************************************************************
  // accumulators
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      crc_q <= CRC_INIT;
      sum_q <= 8'h00;
    end else if (en_i) begin
      crc_q <= crc_step(crc_q, byte_i);
      sum_q <= sum_q + byte_i;
    end
  end

  assign crc_o = crc_q;
  assign lrc_o = 8'(8'h00 - sum_q);
endmodule : mbsc_chk
`default_nettype wire

// *** src/mbsc_slave.sv ***
// modbus slave: coil map, coil writes and register-read framing
`timescale 1ns/1ps
`default_nettype none
module mbsc_slave (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] SLAVE_ADDR_I,
  input wire logic ASCII_MODE_I,
  input wire logic LOW_ALARM_I,
  input wire logic HIGH_ALARM_I,
  input wire logic LOOP_OVER_I,
  input wire logic LOOP_UNDER_I,
  input wire logic TEMP_RANGE_I,
  input wire logic MEAS_RANGE_I,
  input wire logic MEAS_ACTIVE_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_BYTE_I,
  input wire logic RX_END_I,
  input wire logic TX_READY_I,
  input wire logic [15:0] REG_DATA_I,
  input wire logic REG_FLOAT_I,
  output logic TX_VALID_O,
  output logic [7:0] TX_BYTE_O,
  output logic TX_LAST_O,
  output logic [15:0] REG_ADDR_O,
  output logic RELAY_ONE_O,
  output logic RELAY_TWO_O,
  output logic CLEAN_RELAY_O,
  output logic FRAME_ERR_O
);
  import mbsc_pkg::*;
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  logic [15:0] pin_raw;
  logic [7:0] slave_addr;
  logic ascii_mode;
  logic [6:0] status;
  assign pin_raw = {SLAVE_ADDR_I, ASCII_MODE_I, MEAS_ACTIVE_I, MEAS_RANGE_I,
                    TEMP_RANGE_I, LOOP_UNDER_I, LOOP_OVER_I, HIGH_ALARM_I,
                    LOW_ALARM_I};
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      pin_s1_q <= {9'h000, MEAS_RST, 6'h00};
      pin_s2_q <= {9'h000, MEAS_RST, 6'h00};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  assign slave_addr = pin_s2_q[15:8];
  assign ascii_mode = pin_s2_q[7];
  assign status = pin_s2_q[6:0];
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic in_span(input logic [15:0] s,
                                   input logic [15:0] q,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi_excl);
    return (q != 16'h0000) && (s >= lo) &&
           (({1'b0, s} + {1'b0, q}) <= {1'b0, hi_excl});
  endfunction : in_span
  function automatic logic [15:0] n_bytes(input logic [15:0] q);
    return 16'((17'(q) + 17'h00007) >> 3);
  endfunction : n_bytes
  // ****************************************************************
  // receive buffer
  // ****************************************************************
  mbsc_state_type state_q;
  logic [7:0] rx_buf [RX_DEPTH];
  logic [5:0] rx_cnt_q;
  logic rx_ovf_q;
  logic rx_take;
  assign rx_take = (state_q == ST_COLLECT) && RX_VALID_I &&
                   (rx_cnt_q < 6'(RX_DEPTH));
  always_ff @(posedge REF_CLK_I) begin
    if (rx_take) begin
      rx_buf[rx_cnt_q[4:0]] <= RX_BYTE_I;
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || state_q == ST_DECODE) begin
      rx_cnt_q <= 6'h00;
      rx_ovf_q <= 1'b0;
    end else if (rx_take) begin
      rx_cnt_q <= rx_cnt_q + 6'h01;
    end else if (state_q == ST_COLLECT && RX_VALID_I) begin
      rx_ovf_q <= 1'b1;
    end
  end
  // ****************************************************************
  // check fields
  // ****************************************************************
  logic [15:0] rx_crc;
  logic [7:0] rx_lrc;
  logic [15:0] tx_crc;
  logic [7:0] tx_lrc;
  logic tx_chk_en;
  logic chk_clr;
  logic [7:0] tx_next;
  assign chk_clr = (state_q == ST_DECODE);
  mbsc_chk u_rx_chk (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clr_i(chk_clr),
    .en_i(rx_take),
    .byte_i(RX_BYTE_I),
    .crc_o(rx_crc),
    .lrc_o(rx_lrc)
  );
  mbsc_chk u_tx_chk (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clr_i(chk_clr),
    .en_i(tx_chk_en),
    .byte_i(tx_next),
    .crc_o(tx_crc),
    .lrc_o(tx_lrc)
  );
  // ****************************************************************
  // request decode
  // ****************************************************************
  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] qty;
  logic [15:0] wval;
  logic [5:0] trail_len;
  logic chk_ok;
  logic frame_ok;
  logic bcast;
  logic [7:0] exc_code;
  logic [15:0] coil_word;
  logic [15:0] coil_rel;
  logic [15:0] rd_bits;
  logic [15:0] wr_bits;
  logic [RELAY_COUNT-1:0] rly_q;
  logic [RELAY_COUNT-1:0] rly_d;
  logic wr_apply;
  assign fc = rx_buf[1];
  assign start = {rx_buf[2], rx_buf[3]};
  assign qty = {rx_buf[4], rx_buf[5]};
  assign wval = qty;
  assign wr_bits = {rx_buf[8], rx_buf[7]};
  assign trail_len = ascii_mode ? 6'h01 : 6'h02;
  assign chk_ok = ascii_mode ? (rx_lrc == 8'h00) : (rx_crc == 16'h0000);
  assign bcast = (rx_buf[0] == BCAST_ADDR);
  assign frame_ok = !rx_ovf_q && chk_ok &&
                    (rx_cnt_q >= trail_len + RX_MIN_BODY) &&
                    (bcast || rx_buf[0] == slave_addr);
  // coil vector, bit 0 at the first coil address
  assign coil_word = {6'h00, status[6], rly_q, status[5:0]};
  assign coil_rel = start - COIL_LOW_LIMIT_ALARM_FLAG;
  assign rd_bits = (coil_word >> coil_rel[3:0]) &
                   ~(16'hFFFF << qty[4:0]);
  always_comb begin
    exc_code = EXC_NONE;
    case (fc)
      FC_RD_COILS: begin
        if (!in_span(start, qty, COIL_LOW_LIMIT_ALARM_FLAG, COIL_END)) begin
          exc_code = EXC_ADDR;
        end
      end
      FC_RD_HOLD, FC_RD_INPUT: begin
        if (qty == 16'h0000 || qty > MAX_REGS) begin
          exc_code = EXC_VALUE;
        end
      end
      FC_WR_COIL: begin
        if (!in_span(start, 16'h0001, COIL_RELAY_ONE, COIL_MEAS_STATE)) begin
          exc_code = EXC_ADDR;
        end else if (wval != COIL_ON && wval != COIL_OFF) begin
          exc_code = EXC_VALUE;
        end
      end
      FC_WR_COILS: begin
        if (qty == 16'h0000 || {8'h00, rx_buf[6]} != n_bytes(qty) ||
            rx_cnt_q != 6'(7 + rx_buf[6]) + trail_len) begin
          exc_code = EXC_VALUE;
        end else if (!in_span(start, qty, COIL_RELAY_ONE, COIL_MEAS_STATE)) begin
          exc_code = EXC_ADDR;
        end
      end
      default: begin
        exc_code = EXC_FUNC;
      end
    endcase
  end
  // ****************************************************************
  // action coils
  // ****************************************************************
  assign wr_apply = (state_q == ST_DECODE) && frame_ok &&
                    (exc_code == EXC_NONE);
  always_comb begin
    logic [15:0] off;
    off = 16'h0000;
    rly_d = rly_q;
    if (wr_apply && fc == FC_WR_COIL) begin
      off = start - COIL_RELAY_ONE;
      rly_d[off[1:0]] = (wval == COIL_ON);
    end
    if (wr_apply && fc == FC_WR_COILS) begin
      for (int i = 0; i < RELAY_COUNT; i++) begin
        off = 16'(COIL_RELAY_ONE + 16'(i) - start);
        if (off < qty) begin
          rly_d[i] = wr_bits[off[3:0]];
        end
      end
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rly_q <= {RELAY_COUNT{FLAG_RST}};
    end else begin
      rly_q <= rly_d;
    end
  end
  assign RELAY_ONE_O = rly_q[0];
  assign RELAY_TWO_O = rly_q[1];
  assign CLEAN_RELAY_O = rly_q[2];
  // ****************************************************************
  // response build and transmit
  // ****************************************************************
  logic [7:0] tx_buf [TX_DEPTH];
  logic [8:0] wr_q;
  logic [8:0] rd_q;
  logic [1:0] tr_q;
  logic [7:0] rem_q;
  logic fpend_q;
  logic [15:0] hold_q;
  logic tx_load;
  logic [7:0] nb;
  mbsc_state_type next_idle;
  assign tx_load = !TX_VALID_O || TX_READY_I;
  assign tx_chk_en = (state_q == ST_SEND) && tx_load && (rd_q < wr_q);
  assign nb = 8'(n_bytes(qty));
  assign next_idle = bcast ? ST_COLLECT : ST_SEND;
  // byte about to be loaded feeds the reply check field
  assign tx_next = tx_buf[rd_q[7:0]];
  always_ff @(posedge REF_CLK_I) begin
    if (state_q == ST_DECODE) begin
      tx_buf[0] <= rx_buf[0];
      tx_buf[1] <= (exc_code == EXC_NONE) ? fc : (fc | EXC_FLAG);
      tx_buf[2] <= exc_code;
      if (exc_code == EXC_NONE) begin
        case (fc)
          FC_RD_COILS: begin
            tx_buf[2] <= nb;
            tx_buf[3] <= rd_bits[7:0];
            tx_buf[4] <= rd_bits[15:8];
          end
          FC_RD_HOLD, FC_RD_INPUT: begin
            tx_buf[2] <= 8'(qty << 1);
          end
          default: begin
            tx_buf[2] <= rx_buf[2];
            tx_buf[3] <= rx_buf[3];
            tx_buf[4] <= rx_buf[4];
            tx_buf[5] <= rx_buf[5];
          end
        endcase
      end
    end else if (state_q == ST_FETCH &&
                 !(!fpend_q && REG_FLOAT_I && rem_q >= 8'h02)) begin
      tx_buf[wr_q[7:0]] <= REG_DATA_I[15:8];
      tx_buf[8'(wr_q[7:0] + 8'h01)] <= REG_DATA_I[7:0];
      if (fpend_q) begin
        tx_buf[8'(wr_q[7:0] + 8'h02)] <= hold_q[15:8];
        tx_buf[8'(wr_q[7:0] + 8'h03)] <= hold_q[7:0];
      end
    end
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_q <= ST_COLLECT;
      wr_q <= 9'h000;
      rd_q <= 9'h000;
      tr_q <= 2'h0;
      rem_q <= 8'h00;
      fpend_q <= 1'b0;
      hold_q <= 16'h0000;
      REG_ADDR_O <= 16'h0000;
      TX_VALID_O <= 1'b0;
      TX_BYTE_O <= 8'h00;
      TX_LAST_O <= 1'b0;
      FRAME_ERR_O <= 1'b0;
    end else begin
      FRAME_ERR_O <= 1'b0;
      case (state_q)
        ST_COLLECT: begin
          if (RX_END_I) begin
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          rd_q <= 9'h000;
          tr_q <= 2'h0;
          fpend_q <= 1'b0;
          wr_q <= 9'h003;
          state_q <= ST_COLLECT;
          if (!frame_ok) begin
            FRAME_ERR_O <= rx_ovf_q || !chk_ok;
          end else if (exc_code != EXC_NONE) begin
            state_q <= next_idle;
          end else begin
            case (fc)
              FC_RD_COILS: begin
                wr_q <= 9'(9'h003 + {1'b0, nb});
                state_q <= next_idle;
              end
              FC_RD_HOLD, FC_RD_INPUT: begin
                REG_ADDR_O <= start;
                rem_q <= qty[7:0];
                state_q <= bcast ? ST_COLLECT : ST_FETCH;
              end
              default: begin
                wr_q <= 9'h006;
                state_q <= next_idle;
              end
            endcase
          end
        end
        ST_FETCH: begin
          REG_ADDR_O <= REG_ADDR_O + 16'h0001;
          if (!fpend_q && REG_FLOAT_I && rem_q >= 8'h02) begin
            hold_q <= REG_DATA_I;
            fpend_q <= 1'b1;
          end else begin
            fpend_q <= 1'b0;
            wr_q <= wr_q + (fpend_q ? 9'h004 : 9'h002);
            rem_q <= rem_q - (fpend_q ? 8'h02 : 8'h01);
            if (rem_q == (fpend_q ? 8'h02 : 8'h01)) begin
              state_q <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (tx_load) begin
            if (rd_q < wr_q) begin
              TX_BYTE_O <= tx_buf[rd_q[7:0]];
              TX_VALID_O <= 1'b1;
              rd_q <= rd_q + 9'h001;
            end else if (tr_q == 2'h0) begin
              TX_BYTE_O <= ascii_mode ? tx_lrc : tx_crc[7:0];
              TX_VALID_O <= 1'b1;
              TX_LAST_O <= ascii_mode;
              tr_q <= 2'h1;
            end else if (tr_q == 2'h1 && !ascii_mode) begin
              TX_BYTE_O <= tx_crc[15:8];
              TX_LAST_O <= 1'b1;
              tr_q <= 2'h2;
            end else begin
              TX_VALID_O <= 1'b0;
              TX_LAST_O <= 1'b0;
              state_q <= ST_COLLECT;
            end
          end
        end
        default: begin
          state_q <= ST_COLLECT;
        end
      endcase
    end
  end
endmodule : mbsc_slave
`default_nettype wire

// *** verif/mbsc_slave_asserts.sv ***
// assertions on the ports of the coil and register-read slave
`timescale 1ns/1ps
`default_nettype none
module mbsc_slave_asserts (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] SLAVE_ADDR_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_BYTE_I,
  input wire logic RX_END_I,
  input wire logic TX_READY_I,
  input wire logic TX_VALID_O,
  input wire logic [7:0] TX_BYTE_O,
  input wire logic TX_LAST_O,
  input wire logic RELAY_ONE_O,
  input wire logic RELAY_TWO_O,
  input wire logic CLEAN_RELAY_O,
  input wire logic FRAME_ERR_O
);
  logic [5:0] rx_cnt_q;
  logic [7:0] fc_q;
  logic [7:0] tx_cnt_q;
  logic [3:0] gap_q;
  wire logic [2:0] rly = {CLEAN_RELAY_O, RELAY_TWO_O, RELAY_ONE_O};
  wire logic take = TX_VALID_O && TX_READY_I;
  // ****************************************************************
  // helper counters
  // ****************************************************************
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || RX_END_I) rx_cnt_q <= 6'h00;
    else if (RX_VALID_I) rx_cnt_q <= rx_cnt_q + 6'h01;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RX_VALID_I && rx_cnt_q == 6'h01) fc_q <= RX_BYTE_I;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || (take && TX_LAST_O)) tx_cnt_q <= 8'h00;
    else if (take) tx_cnt_q <= tx_cnt_q + 8'h01;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) gap_q <= 4'hF;
    else if (RX_END_I) gap_q <= 4'h0;
    else if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  out_reset_a: assert property (disable iff (1'b0) RST_I |=>
    !TX_VALID_O && rly == 3'h0 && !FRAME_ERR_O)
    else $error("outputs not cleared by reset");
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_BYTE_O) && $stable(TX_LAST_O))
    else $error("reply byte changed before it was taken");
  addr_echo_a: assert property ($rose(TX_VALID_O) |->
    TX_BYTE_O == SLAVE_ADDR_I) else $error("reply lacks own address");
  func_echo_a: assert property (TX_VALID_O && tx_cnt_q == 8'h01 |->
    TX_BYTE_O[6:0] == fc_q[6:0]) else $error("function code not echoed");
  reply_gap_a: assert property (RX_END_I && !TX_VALID_O |=>
    !TX_VALID_O) else $error("reply started before decode");
  last_drop_a: assert property (take && TX_LAST_O |=>
    !TX_VALID_O) else $error("valid stayed up after last byte");
  relay_cause_a: assert property (
    $changed(rly) && !$past(RST_I) |-> gap_q < 4'h8)
    else $error("relay moved without a frame");
  err_pulse_a: assert property (FRAME_ERR_O |=> !FRAME_ERR_O)
    else $error("frame error wider than one cycle");
  cover property (take && TX_LAST_O);
  cover property (FRAME_ERR_O);
  cover property ($rose(RELAY_ONE_O));
endmodule : mbsc_slave_asserts
bind mbsc_slave mbsc_slave_asserts u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .SLAVE_ADDR_I(SLAVE_ADDR_I),
  .RX_VALID_I(RX_VALID_I), .RX_BYTE_I(RX_BYTE_I), .RX_END_I(RX_END_I),
  .TX_READY_I(TX_READY_I), .TX_VALID_O(TX_VALID_O), .TX_BYTE_O(TX_BYTE_O),
  .TX_LAST_O(TX_LAST_O), .RELAY_ONE_O(RELAY_ONE_O),
  .RELAY_TWO_O(RELAY_TWO_O), .CLEAN_RELAY_O(CLEAN_RELAY_O),
  .FRAME_ERR_O(FRAME_ERR_O)
);
`default_nettype wire

// *** verif/mbsc_host.sv ***
// serial host model: request sender, reply sink, register source
`timescale 1ns/1ps
`default_nettype none
module mbsc_host (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [15:0] reg_addr_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_end_o,
  output logic tx_ready_o,
  output logic [15:0] reg_data_o,
  output logic reg_float_o
);
  logic [7:0] req_q[$];
  // ****************************************************************
  // register source, float pair 41C8 CCCD at 0037H
  // ****************************************************************
  always_comb begin
    reg_float_o = (reg_addr_i == 16'h0037);
    case (reg_addr_i)
      16'h0037: reg_data_o = 16'h41C8;
      16'h0038: reg_data_o = 16'hCCCD;
      default: reg_data_o = {reg_addr_i[7:0], ~reg_addr_i[7:0]};
    endcase
  end
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'hA5;
    rx_end_o = 1'b0;
    tx_ready_o = 1'b1;
  end
  always @(posedge clk_i) begin
    #1;
    tx_ready_o = slow_i ? 1'($urandom) : 1'b1;
    if (req_q.size() != 0) begin
      rx_valid_o = 1'b1;
      rx_byte_o = req_q.pop_front();
      rx_end_o = 1'b0;
    end else begin
      rx_end_o = rx_valid_o;
      rx_valid_o = 1'b0;
      rx_byte_o = ~rx_byte_o;
    end
  end
  function automatic logic [15:0] chk(input logic [7:0] b[$], input logic a);
    logic [15:0] c;
    logic [7:0] s;
    c = 16'hFFFF;
    s = 8'h00;
    foreach (b[i]) begin
      s = s + b[i];
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return a ? {8'h00, 8'h00 - s} : c;
  endfunction : chk
  task automatic send(input logic [7:0] b[$], input logic a, input logic bad);
    logic [15:0] c;
    c = chk(b, a) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    if (!a) b.push_back(c[15:8]);
    req_q = {req_q, b};
  endtask : send
endmodule : mbsc_host
`default_nettype wire

// *** verif/tb_mbsc_slave.sv ***
// self-checking bench for the coil and register-read slave
`timescale 1ns/1ps
`default_nettype none
module tb_mbsc_slave;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ascii = 1'b0;
  logic meas = 1'b1;
  logic slow = 1'b0;
  logic [5:0] st = 6'h00;
  logic [2:0] rly = 3'h0;
  logic rx_valid, rx_end, tx_ready, reg_float, tx_valid, tx_last, ferr;
  logic [7:0] rx_byte, tx_byte;
  logic [15:0] reg_addr, reg_data;
  wire logic [2:0] rly_seen;
  logic [8:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  int errs = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  mbsc_slave u_mbsc_slave (
    .REF_CLK_I(clk), .RST_I(rst), .SLAVE_ADDR_I(8'h01), .ASCII_MODE_I(ascii),
    .LOW_ALARM_I(st[0]), .HIGH_ALARM_I(st[1]), .LOOP_OVER_I(st[2]),
    .LOOP_UNDER_I(st[3]), .TEMP_RANGE_I(st[4]), .MEAS_RANGE_I(st[5]),
    .MEAS_ACTIVE_I(meas), .RX_VALID_I(rx_valid), .RX_BYTE_I(rx_byte),
    .RX_END_I(rx_end), .TX_READY_I(tx_ready), .REG_DATA_I(reg_data),
    .REG_FLOAT_I(reg_float), .TX_VALID_O(tx_valid), .TX_BYTE_O(tx_byte),
    .TX_LAST_O(tx_last), .REG_ADDR_O(reg_addr), .RELAY_ONE_O(rly_seen[0]),
    .RELAY_TWO_O(rly_seen[1]), .CLEAN_RELAY_O(rly_seen[2]), .FRAME_ERR_O(ferr)
  );
  mbsc_host u_host (
    .clk_i(clk), .slow_i(slow), .reg_addr_i(reg_addr), .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte), .rx_end_o(rx_end), .tx_ready_o(tx_ready),
    .reg_data_o(reg_data), .reg_float_o(reg_float)
  );
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() + u_host.req_q.size()) != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    #1;
    check(16'(exp_q.size()), 16'h0000);
    exp_q.delete();
  endtask : drain
  task automatic run(input logic [7:0] req[$], input logic [7:0] rsp[$]);
    logic [15:0] c;
    c = u_host.chk(rsp, ascii);
    rsp.push_back(c[7:0]);
    if (!ascii) rsp.push_back(c[15:8]);
    foreach (rsp[i]) exp_q.push_back({i == rsp.size() - 1, rsp[i]});
    u_host.send(req, ascii, 1'b0);
    drain();
  endtask : run
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check({7'h00, tx_last, tx_byte}, 16'hFFFF);
      else check({7'h00, tx_last, tx_byte}, {7'h00, exp_q.pop_front()});
    end
    if (ferr === 1'b1) errs++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [7:0] fq[$];
    logic [7:0] fr[$];
    void'($urandom(49));
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    run('{8'h01, 8'h01, 8'h00, 8'h70, 8'h00, 8'h0A},
      '{8'h01, 8'h01, 8'h02, 8'h00, 8'h02});
    note("reset coils");
    for (int k = 0; k < 3; k++) begin
      run('{8'h01, 8'h05, 8'h00, 8'(8'h76 + k), 8'hFF, 8'h00},
        '{8'h01, 8'h05, 8'h00, 8'(8'h76 + k), 8'hFF, 8'h00});
      rly[k] = 1'b1;
      check({13'h0000, rly_seen}, {13'h0000, rly});
    end
    run('{8'h01, 8'h05, 8'h00, 8'h70, 8'hFF, 8'h00},
      '{8'h01, 8'h85, 8'h02});
    run('{8'h01, 8'h0F, 8'h00, 8'h76, 8'h00, 8'h03, 8'h01, 8'h05},
      '{8'h01, 8'h0F, 8'h00, 8'h76, 8'h00, 8'h03});
    rly = 3'h5;
    check({13'h0000, rly_seen}, {13'h0000, rly});
    note("coil writes");
    for (int k = 0; k < 4; k++) begin
      st = 6'($urandom);
      meas = 1'($urandom);
      ascii = k[0];
      slow = k[1];
      repeat (3) @(posedge clk);
      #1;
      run('{8'h01, 8'h01, 8'h00, 8'h70, 8'h00, 8'h0A},
        '{8'h01, 8'h01, 8'h02, {rly[1:0], st}, {6'h00, meas, rly[2]}});
      run('{8'h01, 8'h01, 8'h00, 8'h76, 8'h00, 8'h04},
        '{8'h01, 8'h01, 8'h01, {4'h0, meas, rly}});
    end
    run('{8'h01, 8'h01, 8'h00, 8'h7A, 8'h00, 8'h01},
      '{8'h01, 8'h81, 8'h02});
    run('{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01},
      '{8'h01, 8'h87, 8'h01});
    note("status coils");
    fq = '{8'h01, 8'h03, 8'h00, 8'h37, 8'h00, 8'h02};
    fr = '{8'h01, 8'h03, 8'h04, 8'hCC, 8'hCD, 8'h41, 8'hC8};
    check(u_host.chk(fq, 1'b0), 16'hC575);
    check(u_host.chk(fr, 1'b1), 16'h0056);
    check(u_host.chk(fq, 1'b1), 16'h00C3);
    check(u_host.chk(fr, 1'b0), 16'h5A65);
    for (int m = 0; m < 2; m++) begin
      ascii = m[0];
      repeat (3) @(posedge clk);
      #1;
      run(fq, fr);
      run('{8'h01, 8'h03, 8'h00, 8'h36, 8'h00, 8'h03}, '{8'h01, 8'h03, 8'h06,
        8'h36, 8'hC9, 8'hCC, 8'hCD, 8'h41, 8'hC8});
      run('{8'h01, 8'h03, 8'h00, 8'h37, 8'h00, 8'h01},
        '{8'h01, 8'h03, 8'h02, 8'h41, 8'hC8});
      run('{8'h01, 8'h04, 8'h00, 8'h10, 8'h00, 8'h01},
        '{8'h01, 8'h04, 8'h02, 8'h10, 8'hEF});
    end
    run('{8'h01, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00},
      '{8'h01, 8'h83, 8'h03});
    note("register reads");
    u_host.send('{8'h01, 8'h01, 8'h00, 8'h70, 8'h00, 8'h01}, ascii, 1'b1);
    drain();
    u_host.send('{8'h02, 8'h01, 8'h00, 8'h70, 8'h00, 8'h01}, ascii, 1'b0);
    drain();
    check(16'(errs), 16'h0001);
    note("dropped frames");
    u_host.send('{8'h00, 8'h05, 8'h00, 8'h76, 8'h00, 8'h00}, ascii, 1'b0);
    drain();
    rly[0] = 1'b0;
    check({13'h0000, rly_seen}, {13'h0000, rly});
    note("broadcast write");
    print_verdict();
  end
endmodule : tb_mbsc_slave
`default_nettype wire
